// >>> hdl/pwr_ctl_pkg.sv
package pwr_ctl_pkg;
    localparam int OSC_PER_MACHINE_CYCLE = 12;
    localparam int RST_MACHINE_CYCLES = 2;
    // oscillator periods the reset pin must stay high
    localparam int RST_HOLD_OSC = OSC_PER_MACHINE_CYCLE * RST_MACHINE_CYCLES;
    localparam int RST_CNT_W = 5;
    localparam logic [RST_CNT_W-1:0] RST_CNT_RESET = 5'h00;
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_PD_BIT = 1;
    localparam int PWR_FLAG0_BIT = 2;
    localparam int PWR_FLAG1_BIT = 3;
    localparam int PWR_BAUD2_BIT = 7;
    localparam logic [7:0] PWR_CTL_RESET = 8'h00;
    localparam logic [7:0] PWR_CTL_WMASK = 8'h8f;
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic STROBE_PD = 1'b0;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_IDLE = 3'b010,
        ST_PD   = 3'b100
    } pmode_t;
endpackage

// >>> hdl/osc_div2.sv
module osc_div2 (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_phase
);
    logic phase_ff;
    logic nxt_phase;

    // toggling flop removes any dependence on the input duty cycle
    always_comb begin
        nxt_phase = i_run ? ~phase_ff : phase_ff;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign o_phase = phase_ff;
endmodule

// >>> hdl/power_mode_reset_control.sv
// Summary of operation
// - oscillator input passes a divide-by-two flop before internal clocking.
// - idle stops cpu after requesting instruction; peripherals keep running.
// - cpu state, ram and special registers are kept unchanged in idle.
// - any enabled interrupt ends idle and its service routine then runs.
// - hardware reset during idle restarts exactly like power-on reset.
// - power-down completes requesting instruction then stops the oscillator.
// - in power-down only on-chip ram contents are guaranteed kept.
// - only hardware reset leaves power-down; interrupts do not.
// - idle and power-down selected by bits in power control register.
// - idle drives both strobes high; external code: port 0 floats, port 2 addr.
// - power-down drives both strobes low; external code: port 0 floats.
module power_mode_reset_control (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rst_pin,
    input wire logic i_ctl_we,
    input wire logic [7:0] i_ctl_wdata,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic i_ext_prog,
    input wire logic i_ale_run,
    input wire logic i_prog_strobe_run,
    input wire logic [7:0] i_p0_run,
    input wire logic i_p0_oe_run,
    input wire logic [7:0] i_p2_run,
    input wire logic [7:0] i_p2_addr,
    output logic [7:0] o_power_ctl_reg,
    output logic o_osc_out_pin,
    output logic o_osc_en,
    output logic o_machine_phase,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_sys_rst,
    output logic o_idle,
    output logic o_pd,
    output logic o_irq_wake,
    output logic o_ale,
    output logic o_prog_store_strobe,
    output logic [7:0] o_p0,
    output logic o_p0_oe,
    output logic [7:0] o_p2
);
    pwr_ctl_pkg::pmode_t mode_ff, nxt_mode;
    logic [7:0] ctl_ff, nxt_ctl;
    logic [pwr_ctl_pkg::RST_CNT_W-1:0] rcnt_ff, nxt_rcnt;
    logic sys_rst_ff, nxt_sys_rst;
    logic wake_ff, nxt_wake;
    logic ale_ff, nxt_ale;
    logic pss_ff, nxt_pss;
    logic [7:0] p0_ff, nxt_p0;
    logic p0_oe_ff, nxt_p0_oe;
    logic [7:0] p2_ff, nxt_p2;
    logic [7:0] p0_hold_ff, nxt_p0_hold;
    logic [7:0] p2_hold_ff, nxt_p2_hold;
    logic phase;
    logic osc_run;
    logic rst_taken;

    localparam logic [pwr_ctl_pkg::RST_CNT_W-1:0] RST_HOLD =
        pwr_ctl_pkg::RST_CNT_W'(pwr_ctl_pkg::RST_HOLD_OSC);

    // oscillator stopped only in power-down
    assign osc_run = (mode_ff != pwr_ctl_pkg::ST_PD);

    osc_div2 u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(osc_run),
        .o_phase(phase)
    );

    // reset pin qualified by a hold count; in power-down the count still
    // runs since the core clock here stands for the restarting oscillator
    assign rst_taken = i_rst_pin && (rcnt_ff >= RST_HOLD - 5'h01);

    always_comb begin
        nxt_rcnt = rcnt_ff;
        if (!i_rst_pin) begin
            nxt_rcnt = pwr_ctl_pkg::RST_CNT_RESET;
        end else if (rcnt_ff < RST_HOLD) begin
            nxt_rcnt = rcnt_ff + 5'h01;
        end
        nxt_sys_rst = rst_taken;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rcnt_ff <= pwr_ctl_pkg::RST_CNT_RESET;
            sys_rst_ff <= 1'b1;
        end else begin
            rcnt_ff <= nxt_rcnt;
            sys_rst_ff <= nxt_sys_rst;
        end
    end

    // mode control
    always_comb begin
        nxt_mode = mode_ff;
        nxt_ctl = ctl_ff;
        nxt_wake = 1'b0;
        if (i_ctl_we && mode_ff == pwr_ctl_pkg::ST_RUN) begin
            nxt_ctl = i_ctl_wdata & pwr_ctl_pkg::PWR_CTL_WMASK;
        end
        if (rst_taken) begin
            nxt_mode = pwr_ctl_pkg::ST_RUN;
            nxt_ctl = pwr_ctl_pkg::PWR_CTL_RESET;
        end else begin
            case (mode_ff)
                pwr_ctl_pkg::ST_RUN: begin
                    if (i_instr_done) begin
                        if (ctl_ff[pwr_ctl_pkg::PWR_PD_BIT]) begin
                            nxt_mode = pwr_ctl_pkg::ST_PD;
                        end else if (ctl_ff[pwr_ctl_pkg::PWR_IDLE_BIT]) begin
                            nxt_mode = pwr_ctl_pkg::ST_IDLE;
                        end
                    end
                end
                pwr_ctl_pkg::ST_IDLE: begin
                    // state kept by gating the cpu clock only
                    if (i_irq_pending) begin
                        nxt_mode = pwr_ctl_pkg::ST_RUN;
                        nxt_wake = 1'b1;
                        nxt_ctl[pwr_ctl_pkg::PWR_IDLE_BIT] = 1'b0;
                    end
                end
                pwr_ctl_pkg::ST_PD: begin
                    nxt_mode = pwr_ctl_pkg::ST_PD;
                end
                default: begin
                    nxt_mode = pwr_ctl_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_ff <= pwr_ctl_pkg::ST_RUN;
            ctl_ff <= pwr_ctl_pkg::PWR_CTL_RESET;
            wake_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            ctl_ff <= nxt_ctl;
            wake_ff <= nxt_wake;
        end
    end

    // pin state; hold registers capture port data on mode entry
    always_comb begin
        nxt_p0_hold = p0_hold_ff;
        nxt_p2_hold = p2_hold_ff;
        if (mode_ff == pwr_ctl_pkg::ST_RUN) begin
            nxt_p0_hold = i_p0_run;
            nxt_p2_hold = i_p2_run;
        end
        nxt_ale = i_ale_run;
        nxt_pss = i_prog_strobe_run;
        nxt_p0 = i_p0_run;
        nxt_p0_oe = i_p0_oe_run;
        nxt_p2 = i_p2_run;
        case (nxt_mode)
            pwr_ctl_pkg::ST_RUN: begin
                nxt_ale = i_ale_run;
            end
            pwr_ctl_pkg::ST_IDLE: begin
                nxt_ale = pwr_ctl_pkg::STROBE_IDLE;
                nxt_pss = pwr_ctl_pkg::STROBE_IDLE;
                nxt_p0 = nxt_p0_hold;
                nxt_p0_oe = ~i_ext_prog;
                nxt_p2 = i_ext_prog ? i_p2_addr : nxt_p2_hold;
            end
            pwr_ctl_pkg::ST_PD: begin
                nxt_ale = pwr_ctl_pkg::STROBE_PD;
                nxt_pss = pwr_ctl_pkg::STROBE_PD;
                nxt_p0 = nxt_p0_hold;
                nxt_p0_oe = ~i_ext_prog;
                nxt_p2 = nxt_p2_hold;
            end
            default: begin
                nxt_ale = i_ale_run;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ale_ff <= 1'b1;
            pss_ff <= 1'b1;
            p0_ff <= 8'hff;
            p0_oe_ff <= 1'b0;
            p2_ff <= 8'hff;
            p0_hold_ff <= 8'hff;
            p2_hold_ff <= 8'hff;
        end else begin
            ale_ff <= nxt_ale;
            pss_ff <= nxt_pss;
            p0_ff <= nxt_p0;
            p0_oe_ff <= nxt_p0_oe;
            p2_ff <= nxt_p2;
            p0_hold_ff <= nxt_p0_hold;
            p2_hold_ff <= nxt_p2_hold;
        end
    end

    assign o_power_ctl_reg = ctl_ff;
    assign o_osc_en = osc_run;
    assign o_osc_out_pin = osc_run & ~phase;
    assign o_machine_phase = phase;
    assign o_cpu_clk_en = (mode_ff == pwr_ctl_pkg::ST_RUN);
    assign o_periph_clk_en = (mode_ff != pwr_ctl_pkg::ST_PD);
    assign o_sys_rst = sys_rst_ff;
    assign o_idle = (mode_ff == pwr_ctl_pkg::ST_IDLE);
    assign o_pd = (mode_ff == pwr_ctl_pkg::ST_PD);
    assign o_irq_wake = wake_ff;
    assign o_ale = ale_ff;
    assign o_prog_store_strobe = pss_ff;
    assign o_p0 = p0_ff;
    assign o_p0_oe = p0_oe_ff;
    assign o_p2 = p2_ff;
endmodule

// >>> verif/pmrc_sva.sv
module pmrc_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rst_pin,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic [7:0] o_power_ctl_reg,
    input wire logic o_osc_en,
    input wire logic o_machine_phase,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_sys_rst,
    input wire logic o_idle,
    input wire logic o_pd,
    input wire logic o_irq_wake,
    input wire logic o_ale,
    input wire logic o_prog_store_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] hi_ff;
    logic [4:0] nxt_hi;
    // saturates so a long hold never wraps into the take window
    always_comb begin
        nxt_hi = &hi_ff ? hi_ff : hi_ff + 5'h01;
        if (!i_rst_pin) nxt_hi = 5'h00;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) hi_ff <= 5'h00;
        else hi_ff <= nxt_hi;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence wake_s;
        !o_idle && o_irq_wake ##1 !o_irq_wake;
    endsequence
    a_idle_strobes: assert property (
        o_idle |-> o_ale && o_prog_store_strobe) else $error("idle strobes");
    a_pd_strobes: assert property (
        o_pd |-> !o_ale && !o_prog_store_strobe && !o_osc_en)
        else $error("pd strobes");
    a_idle_clocks: assert property (
        o_idle |-> !o_cpu_clk_en && o_periph_clk_en) else $error("idle clk");
    a_idle_entry: assert property (
        $rose(o_idle) |-> $past(i_instr_done)) else $error("idle entry");
    a_irq_wake: assert property (
        o_idle && i_irq_pending && !i_rst_pin |=> wake_s) else $error("wake");
    a_pd_hold: assert property (
        o_pd && !i_rst_pin |=> o_pd) else $error("pd left");
    a_both_pd: assert property (
        o_power_ctl_reg[1:0] == 2'b11 && i_instr_done && !o_idle && !o_pd
        && !i_rst_pin |=> o_pd && !o_idle) else $error("both bits");
    a_pin_take: assert property (
        i_rst_pin && hi_ff == 5'h17 |=> o_sys_rst && !o_idle && !o_pd)
        else $error("pin reset");
    a_phase_div: assert property (
        !o_pd ##1 !o_pd |-> o_machine_phase != $past(o_machine_phase))
        else $error("phase");
endmodule
bind power_mode_reset_control pmrc_sva u_sva (.*);

// >>> verif/rst_src.sv
module rst_src (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [5:0] i_len,
    output logic o_rst_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] left_ff;
    logic [5:0] nxt_left;
    // pin held i_len cycles, then the pull-down wins
    always_comb begin
        nxt_left = left_ff == 6'h00 ? 6'h00 : left_ff - 6'h01;
        if (i_go) nxt_left = i_len;
    end
    // power-on: held through reset plus 30 cycles
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) left_ff <= 6'h1e;
        else left_ff <= nxt_left;
    end
    assign o_rst_pin = left_ff != 6'h00;
endmodule

// >>> verif/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_rst_pin, go = 1'b0;
    logic i_ctl_we = 1'b0, i_instr_done = 1'b0, i_irq_pending = 1'b0;
    logic i_ext_prog = 1'b0, i_ale_run = 1'b0, i_prog_strobe_run = 1'b0;
    logic [7:0] p0_q = 8'h00;
    logic i_p0_oe_run = 1'b0, o_osc_out_pin, o_osc_en, o_machine_phase;
    logic [7:0] i_ctl_wdata = 8'h00, i_p0_run = 8'h00, i_p2_run = 8'h00;
    logic [7:0] i_p2_addr = 8'h00, pa_q = 8'h00, o_power_ctl_reg, o_p0, o_p2;
    logic o_periph_clk_en, o_sys_rst, o_pd, o_irq_wake, o_ale, o_p0_oe;
    logic o_prog_store_strobe, o_cpu_clk_en, o_idle;
    logic [5:0] len = 6'h00;
    int seed = 21, n_errors = 0, num_checks = 0, cyc = 0;
    wire logic [7:0] st = {2'b00, o_idle, o_pd, o_ale, o_prog_store_strobe,
        o_cpu_clk_en, o_periph_clk_en};
    power_mode_reset_control u_dut (.*);
    rst_src u_src (.i_clk, .i_rst, .i_go(go), .i_len(len),
        .o_rst_pin(i_rst_pin));
    initial forever #5 i_clk = ~i_clk;
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // a spare cycle keeps back-to-back writes from re-raising the strobe
    task automatic wr_ctl();
        i_ctl_we = 1'b1;
        tick(1);
        i_ctl_we = 1'b0;
        tick(1);
    endtask
    task automatic pin(input logic [5:0] l);
        len = l;
        go = 1'b1;
        tick(1);
        go = 0;
        tick(45);
    endtask
    // idle: strobes high, cpu off; power-down: strobes and both clock enables low
    function automatic logic [7:0] mode_exp(input int m);
        return m == 1 ? 8'h2d : 8'h10;
    endfunction
    always @(posedge i_clk) begin
        #1;
        pa_q = i_p2_addr;
        p0_q = i_p0_run;
        {i_ale_run, i_prog_strobe_run, i_p0_oe_run, i_p0_run} =
            11'($random(seed));
        {i_p2_run, i_p2_addr} = 16'($random(seed));
        cyc++;
        if (cyc > 3000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        tick(40);
        chk({7'h00, o_sys_rst}, 8'h00);
        repeat (6) begin
            i_ctl_wdata = 8'($random(seed));
            wr_ctl();
            chk(o_power_ctl_reg,
                i_ctl_wdata & pwr_ctl_pkg::PWR_CTL_WMASK);
        end
        for (int m = 1; m < 4; m++) begin
            i_ext_prog = m[0];
            i_ctl_wdata = 8'(m);
            wr_ctl();
            i_instr_done = 1'b1;
            tick(1);
            i_instr_done = 1'b0;
            chk(st, mode_exp(m));
            if (m[0]) chk({7'h00, o_p0_oe}, 8'h00);
            @(negedge i_clk);
            if (m == 1) chk(o_p2, pa_q);
            if (m == 2) chk(o_p0, p0_q);
            if (m == 2) chk({7'h00, o_p0_oe}, 8'h01);
            if (m > 1) chk({7'h00, o_osc_out_pin}, 8'h00);
            tick(1);
            i_irq_pending = 1'b1;
            tick(1);
            i_irq_pending = 1'b0;
            chk(st & 8'h30 | 8'(o_irq_wake), m == 1 ? 8'h01 : 8'h10);
            if (m > 1) begin
                pin(6'h0a);
                chk({7'h00, o_pd}, 8'h01);
                pin(6'h1e);
                chk({o_pd, o_power_ctl_reg[6:0]}, 8'h00);
            end
        end
        complete_run();
    end
endmodule
